/* File: design/lcp_pkg.sv */
package lcp_pkg;

	// host data bus and RAM address width
	localparam int LCP_DATA_W = 8;
	localparam int LCP_ADDR_W = 16;
	localparam int LCP_BUSY_BIT = 7;

	// instruction codes
	localparam logic [7:0] LCP_OP_DUTY = 8'h03;
	localparam logic [7:0] LCP_OP_CURSOR_LINE = 8'h04;
	localparam logic [7:0] LCP_OP_START_LO = 8'h08;
	localparam logic [7:0] LCP_OP_START_HI = 8'h09;
	localparam logic [7:0] LCP_OP_CURSOR_LO = 8'h0a;
	localparam logic [7:0] LCP_OP_CURSOR_HI = 8'h0b;
	localparam logic [7:0] LCP_OP_RAM_WRITE = 8'h0c;
	localparam logic [7:0] LCP_OP_RAM_READ = 8'h0d;
	localparam logic [7:0] LCP_OP_BIT_CLEAR = 8'h0e;
	localparam logic [7:0] LCP_OP_BIT_SET = 8'h0f;

	// field layouts
	localparam int LCP_CLINE_W = 4;
	localparam int LCP_BITSEL_W = 3;
	localparam int LCP_HP_W = 3;
	localparam int LCP_CHAR_HI_W = 4;

	// reset values and the address increment
	localparam logic [7:0] LCP_IR_RST = 8'h00;
	localparam logic [7:0] LCP_BYTE_RST = 8'h00;
	localparam logic [15:0] LCP_ADDR_RST = 16'h0000;
	localparam logic [3:0] LCP_CLINE_RST = 4'h0;
	localparam logic [15:0] LCP_ADDR_ONE = 16'h0001;

	// execution sequencer
	typedef enum logic [4:0] {
		LCP_S_IDLE = 5'h01,
		LCP_S_WRITE = 5'h02,
		LCP_S_FETCH = 5'h04,
		LCP_S_WAIT = 5'h08,
		LCP_S_DONE = 5'h10
	} lcp_state_t;

endpackage

/* File: design/lcp_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module lcp_ram #(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 16
) (
	// clock
	input wire logic i_clk,
	input wire logic i_rst_n,
	// single port
	input wire logic i_we,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	output logic [DATA_W-1:0] o_rdata
);

	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rdata_ff;

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end

	// registered read, one cycle after the address
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= mem[i_addr];
		end
	end

	assign o_rdata = rdata_ff;

endmodule // lcp_ram
`default_nettype wire

/* File: design/lcp_instr_port.sv */
// Overview of operation
// - code 03h loads duty divisor minus one, divisor 1 to 256
// - code 04h loads cursor line minus one in four low bits
// - cursor is horizontal_pitch dots long
// - enabled cursor within vertical pitch overrides character dots on row, character mode only
// - cursor line beyond vertical pitch shows no cursor
// - codes 08h and 09h load display start address low and high byte
// - graphic mode uses 16 start bits, character mode only 12
// - top-left display data fetched from display start address
// - codes 0Ah and 0Bh load cursor address counter used for RAM transfers
// - character mode cursor sits at the digit of the cursor address
// - code 0Ch data write stores byte at cursor address, then increments
// - code 0Dh read returns latch, refills it from RAM, increments address
// - codes 0Eh and 0Fh clear or set one RAM bit, then increment
// - bit index one is the LSB, eight the MSB
// - read with register select high returns busy on bit 7
// - busy high while executing, no instruction taken while busy
// - instruction register write leaves busy unchanged
// - busy readable whatever instruction code is held
// - chars per line is even, 2 to 128
// - vertical pitch is 1 to 16 dot rows
// - select high writes instruction code, select low data executes it
`timescale 1ns/1ps
`default_nettype none
module lcp_instr_port
	import lcp_pkg::*;
#(
	parameter int ADDR_W = LCP_ADDR_W
) (
	// clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	// host parallel bus
	input wire logic I_STB,
	input wire logic I_RW,
	input wire logic I_RS,
	input wire logic [7:0] I_DB,
	output logic [7:0] O_DB,
	output logic O_DB_OE,
	output logic O_BUSY,
	// display configuration from other blocks
	input wire logic I_GRAPHIC_MODE,
	input wire logic I_CURSOR_ON,
	input wire logic [LCP_CLINE_W-1:0] I_VERTICAL_PITCH_M1,
	input wire logic [LCP_HP_W-1:0] I_HORIZONTAL_PITCH_M1,
	// display refresh side
	input wire logic [LCP_CLINE_W-1:0] I_SCAN_ROW,
	input wire logic [15:0] I_SCAN_ADDR,
	input wire logic [7:0] I_CHAR_DOTS,
	output logic [7:0] O_ROW_DOTS,
	output logic O_CURSOR_HIT,
	// settings for the refresh logic
	output logic [7:0] O_DUTY_DIVISOR_M1,
	output logic [LCP_CLINE_W-1:0] O_CURSOR_LINE_M1,
	output logic [15:0] O_DISP_START_ADDR,
	output logic [15:0] O_CURSOR_ADDR
);

	// bit select: index minus one, 0 is LSB
	function automatic logic [7:0] bit_mask(
		input logic [LCP_BITSEL_W-1:0] sel
	);
		bit_mask = 8'h01 << sel;
	endfunction

	// cursor bar of (pitch minus one) plus one dots
	function automatic logic [7:0] pitch_mask(
		input logic [LCP_HP_W-1:0] hp_m1
	);
		pitch_mask = 8'hff >> (3'h7 - hp_m1);
	endfunction

	// data write that executes the held instruction code
	function automatic logic op_runs(
		input logic wr,
		input logic [7:0] held,
		input logic [7:0] code
	);
		op_runs = wr & (held == code);
	endfunction

	lcp_state_t state_ff;
	lcp_state_t nxt_state;

	logic [7:0] instr_ff;
	logic [7:0] data_ff;
	logic [7:0] duty_ff;
	logic [LCP_CLINE_W-1:0] cline_ff;
	logic [7:0] start_lo_ff;
	logic [7:0] start_hi_ff;
	logic [15:0] start_eff_ff;
	logic [15:0] cursor_ff;
	logic [7:0] out_latch_ff;
	logic busy_ff;
	logic [7:0] db_ff;
	logic db_oe_ff;
	logic [7:0] dots_ff;
	logic hit_ff;

	logic idle;
	logic host_wr;
	logic host_rd;
	logic instr_wr;
	logic data_wr;
	logic data_rd;
	logic is_bit_op;
	logic ram_we;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;
	logic cursor_inc;
	logic cursor_visible;
	logic cursor_match;

	assign idle = (state_ff == LCP_S_IDLE);
	assign host_wr = I_STB & ~I_RW;
	assign host_rd = I_STB & I_RW;
	// instruction writes and executing accesses only while idle
	assign instr_wr = host_wr & I_RS & idle;
	assign data_wr = host_wr & ~I_RS & idle;
	assign data_rd = host_rd & ~I_RS & idle &
		(instr_ff == LCP_OP_RAM_READ);
	assign is_bit_op = (instr_ff == LCP_OP_BIT_CLEAR) |
		(instr_ff == LCP_OP_BIT_SET);

	// sequencer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			LCP_S_IDLE: begin
				if (data_rd) begin
					nxt_state = LCP_S_FETCH;
				end else if (data_wr) begin
					unique case (instr_ff)
						LCP_OP_RAM_WRITE: nxt_state = LCP_S_WRITE;
						LCP_OP_BIT_CLEAR,
						LCP_OP_BIT_SET: nxt_state = LCP_S_FETCH;
						LCP_OP_DUTY,
						LCP_OP_CURSOR_LINE,
						LCP_OP_START_LO,
						LCP_OP_START_HI,
						LCP_OP_CURSOR_LO,
						LCP_OP_CURSOR_HI: nxt_state = LCP_S_DONE;
						default: nxt_state = LCP_S_IDLE;
					endcase
				end
			end
			LCP_S_WRITE: nxt_state = LCP_S_IDLE;
			LCP_S_FETCH: nxt_state = LCP_S_WAIT;
			LCP_S_WAIT: nxt_state = LCP_S_IDLE;
			LCP_S_DONE: nxt_state = LCP_S_IDLE;
			default: nxt_state = LCP_S_IDLE;
		endcase
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_ff <= LCP_S_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// busy follows the sequencer; instruction writes never start it
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			busy_ff <= 1'b0;
		end else begin
			busy_ff <= (nxt_state != LCP_S_IDLE);
		end
	end

	// instruction register and data byte
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			instr_ff <= LCP_IR_RST;
		end else if (instr_wr) begin
			instr_ff <= I_DB;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			data_ff <= LCP_BYTE_RST;
		end else if (data_wr) begin
			data_ff <= I_DB;
		end
	end

	// duty divisor setting
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			duty_ff <= LCP_BYTE_RST;
		end else if (op_runs(data_wr, instr_ff, LCP_OP_DUTY)) begin
			duty_ff <= I_DB;
		end
	end

	// cursor line setting
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cline_ff <= LCP_CLINE_RST;
		end else if (op_runs(data_wr, instr_ff, LCP_OP_CURSOR_LINE)) begin
			cline_ff <= I_DB[LCP_CLINE_W-1:0];
		end
	end

	// display start address bytes, loaded in either order
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			start_lo_ff <= LCP_BYTE_RST;
			start_hi_ff <= LCP_BYTE_RST;
		end else begin
			if (op_runs(data_wr, instr_ff, LCP_OP_START_LO)) begin
				start_lo_ff <= I_DB;
			end
			if (op_runs(data_wr, instr_ff, LCP_OP_START_HI)) begin
				start_hi_ff <= I_DB;
			end
		end
	end

	// start address as the refresh fetch sees it
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			start_eff_ff <= LCP_ADDR_RST;
		end else if (I_GRAPHIC_MODE) begin
			start_eff_ff <= {start_hi_ff, start_lo_ff};
		end else begin
			start_eff_ff <= {{LCP_CHAR_HI_W{1'b0}},
				start_hi_ff[LCP_CHAR_HI_W-1:0], start_lo_ff};
		end
	end

	// cursor address counter
	assign cursor_inc = (state_ff == LCP_S_WRITE) |
		(state_ff == LCP_S_WAIT);

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cursor_ff <= LCP_ADDR_RST;
		end else if (op_runs(data_wr, instr_ff, LCP_OP_CURSOR_LO)) begin
			cursor_ff <= {cursor_ff[15:8], I_DB};
		end else if (op_runs(data_wr, instr_ff, LCP_OP_CURSOR_HI)) begin
			cursor_ff <= {I_DB, cursor_ff[7:0]};
		end else if (cursor_inc) begin
			cursor_ff <= cursor_ff + LCP_ADDR_ONE;
		end
	end

	// RAM port: write, read prefetch, read-modify-write
	always_comb begin
		ram_we = 1'b0;
		ram_wdata = data_ff;
		if (state_ff == LCP_S_WRITE) begin
			ram_we = 1'b1;
		end else if (state_ff == LCP_S_WAIT && is_bit_op) begin
			ram_we = 1'b1;
			if (instr_ff == LCP_OP_BIT_SET) begin
				ram_wdata = ram_rdata |
					bit_mask(data_ff[LCP_BITSEL_W-1:0]);
			end else begin
				ram_wdata = ram_rdata &
					~bit_mask(data_ff[LCP_BITSEL_W-1:0]);
			end
		end
	end

	lcp_ram #(
		.DATA_W(LCP_DATA_W),
		.ADDR_W(ADDR_W)
	) u_ram (
		.i_clk(I_SYS_CLK),
		.i_rst_n(I_RST_N),
		.i_we(ram_we),
		.i_addr(cursor_ff[ADDR_W-1:0]),
		.i_wdata(ram_wdata),
		.o_rdata(ram_rdata)
	);

	// output latch: stale until the first prefetch completes
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			out_latch_ff <= LCP_BYTE_RST;
		end else if (state_ff == LCP_S_WAIT && !is_bit_op) begin
			out_latch_ff <= ram_rdata;
		end
	end

	// read answer strobe, one cycle after the strobe
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			db_oe_ff <= 1'b0;
		end else begin
			db_oe_ff <= host_rd;
		end
	end

	// read data, held until the next read
	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			db_ff <= LCP_BYTE_RST;
		end else if (host_rd && I_RS) begin
			db_ff <= {busy_ff, {LCP_BUSY_BIT{1'b0}}};
		end else if (data_rd) begin
			db_ff <= out_latch_ff;
		end else if (host_rd) begin
			db_ff <= LCP_BYTE_RST;
		end
	end

	// cursor overlay on the refreshed row
	assign cursor_visible = I_CURSOR_ON & ~I_GRAPHIC_MODE &
		(cline_ff <= I_VERTICAL_PITCH_M1);
	// one RAM address per digit or byte of a line
	assign cursor_match = (I_SCAN_ROW == cline_ff) &
		(I_SCAN_ADDR == cursor_ff);

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			hit_ff <= 1'b0;
		end else begin
			hit_ff <= cursor_visible & cursor_match;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			dots_ff <= LCP_BYTE_RST;
		end else if (cursor_visible && cursor_match) begin
			dots_ff <= pitch_mask(I_HORIZONTAL_PITCH_M1);
		end else begin
			dots_ff <= I_CHAR_DOTS;
		end
	end

	assign O_DB = db_ff;
	assign O_DB_OE = db_oe_ff;
	assign O_BUSY = busy_ff;
	assign O_ROW_DOTS = dots_ff;
	assign O_CURSOR_HIT = hit_ff;
	assign O_DUTY_DIVISOR_M1 = duty_ff;
	assign O_CURSOR_LINE_M1 = cline_ff;
	assign O_DISP_START_ADDR = start_eff_ff;
	assign O_CURSOR_ADDR = cursor_ff;

endmodule // lcp_instr_port
`default_nettype wire

/* File: tb/lcp_instr_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module lcp_instr_port_asserts
	import lcp_pkg::*;
(
	// host bus
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	input wire logic I_STB,
	input wire logic I_RW,
	input wire logic I_RS,
	input wire logic [7:0] O_DB,
	input wire logic O_DB_OE,
	input wire logic O_BUSY,
	// refresh side
	input wire logic [LCP_CLINE_W-1:0] I_VERTICAL_PITCH_M1,
	input wire logic [LCP_HP_W-1:0] I_HORIZONTAL_PITCH_M1,
	input wire logic [LCP_CLINE_W-1:0] I_SCAN_ROW,
	input wire logic [7:0] I_CHAR_DOTS,
	input wire logic [7:0] O_ROW_DOTS,
	input wire logic O_CURSOR_HIT,
	input wire logic [LCP_CLINE_W-1:0] O_CURSOR_LINE_M1
);
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);
	a_busy_read: assert property (I_STB && I_RW && I_RS
		|=> O_DB_OE && O_DB == {$past(O_BUSY), 7'h00}) else $error("busy read");
	a_read_only: assert property (!(I_STB && I_RW) |=> !O_DB_OE)
		else $error("stray read answer");
	a_ir_quiet: assert property (I_STB && !I_RW && I_RS && !O_BUSY
		|=> !O_BUSY) else $error("busy after code write");
	a_busy_len: assert property ($rose(O_BUSY) |-> ##[1:2] !O_BUSY)
		else $error("busy too long");
	a_busy_cause: assert property ($rose(O_BUSY) |->
		($past(I_STB) && !$past(I_RS)) || ($past(I_STB, 2) && !$past(I_RS, 2)))
		else $error("busy without data access");
	a_hit_cause: assert property (O_CURSOR_HIT |->
		$past(I_SCAN_ROW) == $past(O_CURSOR_LINE_M1)
		&& $past(O_CURSOR_LINE_M1) <= $past(I_VERTICAL_PITCH_M1))
		else $error("cursor hit off line");
	a_bar_len: assert property (O_CURSOR_HIT |-> O_ROW_DOTS ==
		8'hff >> (3'h7 - $past(I_HORIZONTAL_PITCH_M1))) else $error("bar");
	a_dots_pass: assert property ($past(I_RST_N) && !O_CURSOR_HIT
		|-> O_ROW_DOTS == $past(I_CHAR_DOTS)) else $error("dots changed");
endmodule // lcp_instr_port_asserts

bind lcp_instr_port lcp_instr_port_asserts u_chk (
	.I_SYS_CLK, .I_RST_N, .I_STB, .I_RW, .I_RS, .O_DB, .O_DB_OE, .O_BUSY,
	.I_VERTICAL_PITCH_M1, .I_HORIZONTAL_PITCH_M1, .I_SCAN_ROW,
	.I_CHAR_DOTS, .O_ROW_DOTS, .O_CURSOR_HIT, .O_CURSOR_LINE_M1
);
`default_nettype wire

/* File: tb/lcp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lcp_host_model (
	// answers from the device
	input wire logic i_clk,
	input wire logic [7:0] i_db,
	input wire logic i_oe,
	// host bus
	output logic o_stb = 1'b0,
	output logic o_rw = 1'b0,
	output logic o_rs = 1'b0,
	output logic [7:0] o_db = 8'h00
);
	task automatic acc(input logic rw, input logic rs,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge i_clk);
		#1;
		o_stb = 1'b1;
		o_rw = rw;
		o_rs = rs;
		o_db = d;
		@(posedge i_clk);
		#1;
		o_stb = 1'b0;
		// released bus must not keep the last value
		o_db = ~d;
		q = (i_oe === 1'b1) ? i_db : 8'hxx;
	endtask
	task automatic idle();
		logic [7:0] q;
		repeat (16) begin
			acc(1'b1, 1'b1, 8'h00, q);
			if (q[7] === 1'b0)
				return;
		end
	endtask
endmodule // lcp_host_model
`default_nettype wire

/* File: tb/lcp_instr_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module lcp_instr_port_test;
	logic clk = 1'b0;
	logic rst_n, stb, rw, rs, oe, busy, gm, con, hit;
	logic [7:0] wdb, rdb, cdots, rdots, duty, q;
	logic [3:0] vp, row, cline;
	logic [2:0] hp;
	logic [15:0] saddr, start, caddr;
	int mismatches = 0;
	int num_checks = 0;
	int cycles = 0;

	lcp_instr_port uut (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_STB(stb),
		.I_RW(rw), .I_RS(rs), .I_DB(wdb), .O_DB(rdb), .O_DB_OE(oe),
		.O_BUSY(busy), .I_GRAPHIC_MODE(gm), .I_CURSOR_ON(con),
		.I_VERTICAL_PITCH_M1(vp), .I_HORIZONTAL_PITCH_M1(hp),
		.I_SCAN_ROW(row), .I_SCAN_ADDR(saddr), .I_CHAR_DOTS(cdots),
		.O_ROW_DOTS(rdots), .O_CURSOR_HIT(hit), .O_DUTY_DIVISOR_M1(duty),
		.O_CURSOR_LINE_M1(cline), .O_DISP_START_ADDR(start),
		.O_CURSOR_ADDR(caddr));
	lcp_host_model hm (.i_clk(clk), .i_db(rdb), .i_oe(oe), .o_stb(stb),
		.o_rw(rw), .o_rs(rs), .o_db(wdb));

	always #2 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			stop_test();
		end
	end

	task automatic chk(input logic [15:0] seen, exp, input string nm);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] d);
		hm.idle();
		hm.acc(1'b0, 1'b1, c, q);
		hm.idle();
		hm.acc(1'b0, 1'b0, d, q);
	endtask
	// point at byte 5 and throw away the stale latch
	task automatic rd_at5();
		cmd(8'h0a, 8'h05);
		cmd(8'h0b, 8'h00);
		hm.idle();
		hm.acc(1'b0, 1'b1, 8'h0d, q);
		hm.acc(1'b1, 1'b0, 8'h00, q);
	endtask
	task automatic rdd(input logic [7:0] exp);
		hm.idle();
		hm.acc(1'b1, 1'b0, 8'h00, q);
		chk(q, exp, "ram");
	endtask

	task automatic t_regs();
		cmd(8'h03, 8'h7f);
		cmd(8'h04, 8'h0f);
		cmd(8'h08, 8'h34);
		cmd(8'h09, 8'hab);
		gm = 1'b1;
		hm.idle();
		chk(duty, 8'h7f, "duty");
		chk(cline, 4'hf, "cline");
		chk(start, 16'hab34, "start");
		gm = 1'b0;
		hm.idle();
		chk(start, 16'h0b34, "start chr");
		$display("regs done");
	endtask
	task automatic t_ram();
		cmd(8'h0a, 8'h05);
		cmd(8'h0b, 8'h00);
		hm.idle();
		chk(caddr, 16'h0005, "caddr");
		cmd(8'h0c, 8'ha5);
		hm.idle();
		hm.acc(1'b0, 1'b0, 8'h5a, q);
		hm.idle();
		chk(caddr, 16'h0007, "caddr wr");
		rd_at5();
		rdd(8'ha5);
		rdd(8'h5a);
		hm.idle();
		chk(caddr, 16'h0008, "caddr rd");
		$display("ram done");
	endtask
	task automatic t_bits();
		cmd(8'h0a, 8'h05);
		cmd(8'h0b, 8'h00);
		cmd(8'h0e, 8'h00);
		hm.acc(1'b1, 1'b1, 8'h00, q);
		chk(q, 8'h80, "busy");
		cmd(8'h0f, 8'h07);
		hm.acc(1'b0, 1'b1, 8'h0a, q);
		hm.idle();
		hm.acc(1'b0, 1'b0, 8'h00, q);
		hm.idle();
		chk(caddr, 16'h0008, "caddr bit");
		rd_at5();
		rdd(8'ha4);
		rdd(8'hda);
		hm.idle();
		hm.acc(1'b0, 1'b1, 8'h0c, q);
		hm.acc(1'b1, 1'b1, 8'h00, q);
		chk(q, 8'h00, "busy ir");
		$display("bits done");
	endtask
	task automatic t_cursor();
		con = 1'b1;
		vp = 4'h7;
		hp = 3'h5;
		cmd(8'h0a, 8'h40);
		cmd(8'h0b, 8'h00);
		row = 4'hf;
		saddr = 16'h0040;
		cdots = 8'h81;
		hm.idle();
		chk(hit, 1'b0, "hit far");
		chk(rdots, 8'h81, "dots");
		cmd(8'h04, 8'h07);
		row = 4'h7;
		hm.idle();
		chk(hit, 1'b1, "hit");
		chk(rdots, 8'h3f, "bar");
		con = 1'b0;
		hm.idle();
		chk(hit, 1'b0, "hit off");
		chk(rdots, 8'h81, "dots off");
		{con, gm} = 2'b11;
		hm.idle();
		chk(hit, 1'b0, "hit gfx");
		gm = 1'b0;
		saddr = 16'h0041;
		hm.idle();
		chk(hit, 1'b0, "hit addr");
		$display("cursor done");
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		rst_n = 1'b0;
		{gm, con, vp, hp, row, saddr, cdots} = '0;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_regs();
		t_ram();
		t_bits();
		t_cursor();
		stop_test();
	end
endmodule // lcp_instr_port_test
`default_nettype wire
